// ### fbc_pkg.sv
// Constants, register map and carrier types of the frame basic classifier.
// Assumes one ingress port per instance and an Avalon-MM register master.
package fbc_pkg;
	localparam int FBC_AW = 10;
	localparam int FBC_DW = 32;
	// Word indices (byte address = 4 * index)
	localparam logic [7:0] FBC_IX_TPID = 8'h00;
	localparam logic [7:0] FBC_IX_FILT = 8'h01;
	localparam logic [7:0] FBC_IX_QOS = 8'h02;
	localparam logic [7:0] FBC_IX_CTPID0 = 8'h03;
	localparam logic [7:0] FBC_IX_CTPID2 = 8'h05;
	localparam logic [7:0] FBC_IX_STAT = 8'h06;
	localparam logic [3:0] FBC_PMAP_HI = 4'h1;
	localparam logic [1:0] FBC_DCFG_HI = 2'h1;
	localparam logic [4:0] FBC_REWR_HI = 5'h10;
	localparam logic [2:0] FBC_CPU_HI = 3'h6;
	// Recognised tag protocol identifiers
	localparam logic [15:0] FBC_TPID_C = 16'h8100;
	localparam logic [15:0] FBC_TPID_S = 16'h88A8;
	localparam int FBC_NTPID = 5;
	localparam int FBC_NTAG = 3;
	// Control-protocol destination block
	localparam logic [41:0] FBC_L2CP_PFX = 42'h0603080000;
	localparam logic [47:0] FBC_NULL_MAC = 48'h000000000000;
	localparam int FBC_MC_BIT = 40;
	// Reset values and the classifier pipeline point
	localparam logic [14:0] FBC_TPID_DIS_RST = 15'h0000;
	localparam logic [3:0] FBC_RT_EN_RST = 4'h0;
	localparam logic [3:0] FBC_PP_CLASSIFIER = 4'h3;
	typedef enum logic [1:0] {
		FBC_STG_ANY = 2'h0,
		FBC_STG_REQUIRE = 2'h1,
		FBC_STG_FORBID = 2'h2
	} fbc_stage_e;
	typedef struct packed {
		logic [47:0] dmac;
		logic [47:0] smac;
		logic [1:0] tag_cnt;
		logic over3;
		logic [2:0][15:0] tpid;
		logic [2:0][15:0] tci;
		logic is_ip;
		logic [5:0] dscp;
		logic cpu_redir;
		logic [3:0] pipeline_point;
	} fbc_frame_s;
	typedef struct packed {
		logic routable;
		logic discard;
		logic vlan_reject;
		logic learn_disable;
		logic [3:0] pipeline_point;
		logic [2:0] classified_priority_class;
		logic [1:0] classified_drop_level;
		logic [5:0] dscp;
		logic codepoint_transparent_flag;
	} fbc_result_s;
	typedef struct packed {
		logic trust;
		logic [2:0] cls;
		logic [1:0] dp;
		logic xlate;
		logic [5:0] xval;
		logic rewrite;
	} fbc_dcfg_s;
endpackage : fbc_pkg

// ### fbc_classifier.sv
// Frame basic classifier: routability, acceptance filtering, QoS/DP/DSCP.
// Assumes a parser feeding one frame per handshake and an Avalon-MM master.
// Operation
// RULE1 - Routable only when all tags valid and routing enabled for tag count.
// RULE2 - Per-position TPID validity setting, shared with VLAN classification.
// RULE3 - Routable count enable: bit0 untagged, bit1 exactly one tag.
// RULE4 - Disable mask bit invalidates a TPID per position; 0x7FFE keeps outer C-tag.
// RULE5 - Routable result is signalled downstream to the routing stage.
// RULE6 - Optionally discard frames whose source MAC has bit 40 set.
// RULE7 - Optionally discard frames with all-zero source or destination MAC.
// RULE8 - Three independently configured acceptance stages, one per tag position.
// RULE9 - Untagged control-protocol frames bypass the acceptance filter.
// RULE10 - Control protocol: DMAC 0180C2000000-0F, 20-2F, 30-3F.
// RULE11 - Tagged control-protocol frames go through the acceptance filter normally.
// RULE12 - Discarded frames get classifier pipeline point and learning disabled.
// RULE13 - QoS class is three bits, seven highest, carried in header.
// RULE14 - Drop level is two bits, three most droppable, carried in header.
// RULE15 - DSCP is six bits to the rewriter, IP frames only.
// RULE16 - DSCP taken behind up to three tags; zero for non-IP.
// RULE17 - PCP/DEI from tag; option selects inner tag on double-tagged frames.
// RULE18 - CPU-redirected control frames take a class from a 32-entry table.
// RULE19 - Sixteen-entry table maps DEI and PCP to drop level and class.
// RULE20 - One configuration entry for each of 64 DSCP values.
// RULE21 - One DSCP rewrite value for each of eight classes.
// RULE22 - Keep enable sets the transparent DSCP flag in the header.
// RULE23 - Class, drop level and DSCP stay open to later override.
// RULE24 - TPIDs are 0x8100, 0x88A8 and three programmable custom values.
// RULE25 - More than three tags means non-IP: no DSCP, not routable.
// RULE26 - Results for a frame leave together, in frame order.
`timescale 1ns/1ns
module fbc_classifier (
	input wire logic CLK,
	input wire logic RST,
	input wire logic CE,
	input wire logic [fbc_pkg::FBC_AW-1:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [fbc_pkg::FBC_DW-1:0] AVS_WRITEDATA,
	output logic [fbc_pkg::FBC_DW-1:0] AVS_READDATA,
	output logic AVS_WAITREQUEST,
	input wire fbc_pkg::fbc_frame_s FRM_IN,
	input wire logic FRM_IN_VALID,
	output logic FRM_IN_READY,
	output fbc_pkg::fbc_result_s RES_OUT,
	output logic RES_OUT_VALID,
	input wire logic RES_OUT_READY
);
	import fbc_pkg::*;

	typedef struct packed {
		logic [14:0] tpid_dis;
		logic [3:0] rt_en;
		logic filt_mc;
		logic filt_null;
		logic [2:0][1:0] stage;
		logic inner_sel;
		logic pcp_trust;
		logic dscp_trust;
		logic keep;
		logic [2:0] def_cls;
		logic [1:0] def_dp;
		logic [2:0][15:0] ctpid;
		logic [15:0][4:0] pmap;
		logic [63:0][13:0] dcfg;
		logic [7:0][5:0] rewr;
		logic [31:0][2:0] cpucls;
		logic ack;
		logic [31:0] rdata;
		logic ovalid;
		fbc_result_s ores;
		logic [15:0] frm_cnt;
		logic [15:0] drop_cnt;
	} fbc_state_s;

	fbc_state_s st_reg;
	fbc_state_s st_next;
	logic [7:0] widx;
	logic req;
	logic wr_fire;
	logic in_fire;
	logic [2:0] tag_ok;
	logic [1:0] vcnt;
	logic all_valid;
	logic is_l2cp;
	logic stage_rej;
	logic drop_sa;
	logic drop_null;
	logic [3:0] pm_idx;
	fbc_dcfg_s dc;
	fbc_result_s res;
	logic [15:0] tp;
	logic [2:0] ttype;

	assign widx = AVS_ADDRESS[9:2];
	assign req = AVS_READ | AVS_WRITE;
	assign wr_fire = CE & AVS_WRITE & st_reg.ack;
	assign AVS_WAITREQUEST = req & ~st_reg.ack;
	assign AVS_READDATA = st_reg.rdata;
	assign FRM_IN_READY = ~st_reg.ovalid | RES_OUT_READY;
	assign in_fire = CE & FRM_IN_VALID & FRM_IN_READY;
	assign RES_OUT_VALID = st_reg.ovalid;
	assign RES_OUT = st_reg.ores;

	// Tag validity per position from TPID kind and disable mask
	always_comb begin
		tag_ok = '0;
		tp = '0;
		ttype = '0;
		for (int i = 0; i < FBC_NTAG; i++) begin
			tp = FRM_IN.tpid[i];
			ttype = 3'h7;
			if (tp == FBC_TPID_C) begin // [RULE24]
				ttype = 3'h0;
			end else if (tp == FBC_TPID_S) begin
				ttype = 3'h1;
			end else begin
				for (int k = 0; k < FBC_NTAG; k++) begin
					if (tp == st_reg.ctpid[k] && ttype == 3'h7) begin
						ttype = 3'(k + 2);
					end
				end
			end
			// Set mask bit invalidates TPID for that position [RULE2] [RULE4]
			if (ttype != 3'h7) begin
				tag_ok[i] = ~st_reg.tpid_dis[i * FBC_NTPID + int'(ttype)];
			end
		end
	end

	// Parsing stops at the first invalid TPID
	always_comb begin
		vcnt = 2'h0;
		if (FRM_IN.tag_cnt >= 2'h1 && tag_ok[0]) begin
			vcnt = 2'h1;
			if (FRM_IN.tag_cnt >= 2'h2 && tag_ok[1]) begin
				vcnt = 2'h2;
				if (FRM_IN.tag_cnt == 2'h3 && tag_ok[2]) begin
					vcnt = 2'h3;
				end
			end
		end
	end

	assign all_valid = (vcnt == FRM_IN.tag_cnt) & ~FRM_IN.over3;
	// Sub-block 10-1F of the prefix is not control protocol
	assign is_l2cp = (FRM_IN.dmac[47:6] == FBC_L2CP_PFX) & // [RULE10]
		(FRM_IN.dmac[5] | ~FRM_IN.dmac[4]);
	assign drop_sa = st_reg.filt_mc & FRM_IN.smac[FBC_MC_BIT]; // [RULE6]
	assign drop_null = st_reg.filt_null & // [RULE7]
		(FRM_IN.smac == FBC_NULL_MAC || FRM_IN.dmac == FBC_NULL_MAC);

	// Three acceptance stages, one per tag position [RULE8] [RULE11]
	always_comb begin
		stage_rej = 1'b0;
		for (int i = 0; i < FBC_NTAG; i++) begin
			if (fbc_stage_e'(st_reg.stage[i]) == FBC_STG_REQUIRE && vcnt <= 2'(i)) begin
				stage_rej = 1'b1;
			end
			if (fbc_stage_e'(st_reg.stage[i]) == FBC_STG_FORBID && vcnt > 2'(i)) begin
				stage_rej = 1'b1;
			end
		end
		if (vcnt == 2'h0 && FRM_IN.tag_cnt == 2'h0 && is_l2cp) begin
			stage_rej = 1'b0; // [RULE9]
		end
	end

	// Inner tag only with two or more valid tags [RULE17]
	assign pm_idx = (st_reg.inner_sel && vcnt >= 2'h2) ?
		{FRM_IN.tci[1][12], FRM_IN.tci[1][15:13]} :
		{FRM_IN.tci[0][12], FRM_IN.tci[0][15:13]};
	assign dc = fbc_dcfg_s'(st_reg.dcfg[FRM_IN.dscp]); // [RULE20]

	always_comb begin
		res = '0;
		res.pipeline_point = FRM_IN.pipeline_point;
		// Over three tags counts as non-IP [RULE25]
		res.routable = FRM_IN.is_ip & ~FRM_IN.over3 & all_valid & // [RULE1] [RULE5]
			st_reg.rt_en[FRM_IN.tag_cnt]; // [RULE3]
		res.vlan_reject = stage_rej;
		res.discard = drop_sa | drop_null | stage_rej;
		if (res.discard) begin
			res.pipeline_point = FBC_PP_CLASSIFIER; // [RULE12]
			res.learn_disable = 1'b1;
		end
		res.classified_priority_class = st_reg.def_cls; // [RULE13]
		res.classified_drop_level = st_reg.def_dp; // [RULE14]
		if (st_reg.pcp_trust && vcnt != 2'h0) begin
			res.classified_priority_class = st_reg.pmap[pm_idx][2:0]; // [RULE19]
			res.classified_drop_level = st_reg.pmap[pm_idx][4:3];
		end
		if (FRM_IN.is_ip && !FRM_IN.over3) begin
			res.dscp = dc.xlate ? dc.xval : FRM_IN.dscp; // [RULE15] [RULE16]
			if (st_reg.dscp_trust && dc.trust) begin
				res.classified_priority_class = dc.cls;
				res.classified_drop_level = dc.dp;
			end
		end
		if (is_l2cp && FRM_IN.cpu_redir) begin // [RULE18]
			res.classified_priority_class =
				st_reg.cpucls[{FRM_IN.dmac[5], FRM_IN.dmac[3:0]}];
		end
		if (FRM_IN.is_ip && !FRM_IN.over3 && dc.rewrite) begin // [RULE21]
			res.dscp = st_reg.rewr[res.classified_priority_class];
		end
		res.codepoint_transparent_flag = st_reg.keep; // [RULE22]
	end

	always_comb begin
		st_next = st_reg;
		// One wait state, then the answer
		st_next.ack = req & ~st_reg.ack;
		if (req && !st_reg.ack) begin
			st_next.rdata = '0;
			if (widx == FBC_IX_TPID) begin
				st_next.rdata = {12'h000, st_reg.rt_en, 1'b0, st_reg.tpid_dis};
			end else if (widx == FBC_IX_FILT) begin
				st_next.rdata = {24'h000000, st_reg.stage, st_reg.filt_null, st_reg.filt_mc};
			end else if (widx == FBC_IX_QOS) begin
				st_next.rdata = {23'h000000, st_reg.def_dp, st_reg.def_cls,
					st_reg.keep, st_reg.dscp_trust, st_reg.pcp_trust, st_reg.inner_sel};
			end else if (widx >= FBC_IX_CTPID0 && widx <= FBC_IX_CTPID2) begin
				st_next.rdata = {16'h0000, st_reg.ctpid[2'(widx - FBC_IX_CTPID0)]};
			end else if (widx == FBC_IX_STAT) begin
				st_next.rdata = {st_reg.drop_cnt, st_reg.frm_cnt};
			end else if (widx[7:4] == FBC_PMAP_HI) begin
				st_next.rdata = {27'h0000000, st_reg.pmap[widx[3:0]]};
			end else if (widx[7:6] == FBC_DCFG_HI) begin
				st_next.rdata = {18'h00000, st_reg.dcfg[widx[5:0]]};
			end else if (widx[7:3] == FBC_REWR_HI) begin
				st_next.rdata = {26'h0000000, st_reg.rewr[widx[2:0]]};
			end else if (widx[7:5] == FBC_CPU_HI) begin
				st_next.rdata = {29'h00000000, st_reg.cpucls[widx[4:0]]};
			end
		end
		if (wr_fire) begin
			if (widx == FBC_IX_TPID) begin
				st_next.tpid_dis = AVS_WRITEDATA[14:0];
				st_next.rt_en = AVS_WRITEDATA[19:16];
			end else if (widx == FBC_IX_FILT) begin
				st_next.filt_mc = AVS_WRITEDATA[0];
				st_next.filt_null = AVS_WRITEDATA[1];
				st_next.stage = AVS_WRITEDATA[7:2];
			end else if (widx == FBC_IX_QOS) begin
				st_next.inner_sel = AVS_WRITEDATA[0];
				st_next.pcp_trust = AVS_WRITEDATA[1];
				st_next.dscp_trust = AVS_WRITEDATA[2];
				st_next.keep = AVS_WRITEDATA[3];
				st_next.def_cls = AVS_WRITEDATA[6:4];
				st_next.def_dp = AVS_WRITEDATA[8:7];
			end else if (widx >= FBC_IX_CTPID0 && widx <= FBC_IX_CTPID2) begin
				st_next.ctpid[2'(widx - FBC_IX_CTPID0)] = AVS_WRITEDATA[15:0];
			end else if (widx == FBC_IX_STAT) begin
				st_next.frm_cnt = '0;
				st_next.drop_cnt = '0;
			end else if (widx[7:4] == FBC_PMAP_HI) begin
				st_next.pmap[widx[3:0]] = AVS_WRITEDATA[4:0];
			end else if (widx[7:6] == FBC_DCFG_HI) begin
				st_next.dcfg[widx[5:0]] = AVS_WRITEDATA[13:0];
			end else if (widx[7:3] == FBC_REWR_HI) begin
				st_next.rewr[widx[2:0]] = AVS_WRITEDATA[5:0];
			end else if (widx[7:5] == FBC_CPU_HI) begin
				st_next.cpucls[widx[4:0]] = AVS_WRITEDATA[2:0];
			end
		end
		// Single output stage keeps frame order [RULE26]
		if (st_reg.ovalid && RES_OUT_READY) begin
			st_next.ovalid = 1'b0;
		end
		if (in_fire) begin
			st_next.ovalid = 1'b1;
			st_next.ores = res; // [RULE23]
			st_next.frm_cnt = st_next.frm_cnt + 16'h0001;
			if (res.discard) begin
				st_next.drop_cnt = st_next.drop_cnt + 16'h0001;
			end
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			st_reg <= '0;
			st_reg.tpid_dis <= FBC_TPID_DIS_RST;
			st_reg.rt_en <= FBC_RT_EN_RST;
		end else if (CE) begin
			st_reg <= st_next;
		end
	end

	// Checks
	AST_OVER3: assert property (@(posedge CLK) disable iff (RST) // [RULE25]
		in_fire && FRM_IN.over3 |=> !RES_OUT.routable && RES_OUT.dscp == 6'h00)
		else $error("frame over three tags routable or has DSCP");
	AST_NONIP: assert property (@(posedge CLK) disable iff (RST) // [RULE16]
		in_fire && !FRM_IN.is_ip |=> RES_OUT.dscp == 6'h00 && !RES_OUT.routable)
		else $error("non-IP frame has DSCP or is routable");
	AST_SMAC_MC: assert property (@(posedge CLK) disable iff (RST) // [RULE6]
		in_fire && st_reg.filt_mc && FRM_IN.smac[FBC_MC_BIT] |=> RES_OUT.discard)
		else $error("multicast source not discarded");
	AST_NULL: assert property (@(posedge CLK) disable iff (RST) // [RULE7]
		in_fire && st_reg.filt_null && FRM_IN.dmac == FBC_NULL_MAC |=> RES_OUT.discard)
		else $error("null destination not discarded");
	AST_BYPASS: assert property (@(posedge CLK) disable iff (RST) // [RULE9]
		in_fire && is_l2cp && FRM_IN.tag_cnt == 2'h0 |=> !RES_OUT.vlan_reject)
		else $error("untagged control frame rejected by tag filter");
	AST_DISCARD_PT: assert property (@(posedge CLK) disable iff (RST) // [RULE12]
		RES_OUT_VALID && RES_OUT.discard |->
		RES_OUT.pipeline_point == FBC_PP_CLASSIFIER && RES_OUT.learn_disable)
		else $error("discarded frame lacks pipeline point or learn disable");
	AST_KEEP: assert property (@(posedge CLK) disable iff (RST) // [RULE22]
		in_fire |=> RES_OUT.codepoint_transparent_flag == $past(st_reg.keep))
		else $error("transparent flag differs from keep enable");
	AST_UNTAG_ONLY: assert property (@(posedge CLK) disable iff (RST) // [RULE3]
		in_fire && st_reg.rt_en == 4'h1 && FRM_IN.tag_cnt != 2'h0 |=> !RES_OUT.routable)
		else $error("tagged frame routable with untagged-only enable");
	AST_HOLD: assert property (@(posedge CLK) disable iff (RST) // [RULE26]
		RES_OUT_VALID && !RES_OUT_READY |=> RES_OUT_VALID && $stable(RES_OUT))
		else $error("result changed under back-pressure");
	AST_BUS_ANSWER: assert property (@(posedge CLK) disable iff (RST)
		CE && req && !st_reg.ack ##1 CE && req |-> !AVS_WAITREQUEST)
		else $error("bus request not answered after one wait state");
	COV_ROUTE: cover property (@(posedge CLK) disable iff (RST)
		RES_OUT_VALID && RES_OUT.routable);
	COV_DISCARD: cover property (@(posedge CLK) disable iff (RST)
		RES_OUT_VALID && RES_OUT.discard);
	COV_BYPASS: cover property (@(posedge CLK) disable iff (RST)
		in_fire && is_l2cp && FRM_IN.tag_cnt == 2'h0 && st_reg.stage[0] == 2'h1);
	COV_STALL: cover property (@(posedge CLK) disable iff (RST)
		RES_OUT_VALID && !RES_OUT_READY ##1 RES_OUT_READY);
endmodule : fbc_classifier

// ### fbc_sink_model.sv
// Downstream stage model: takes classifier results, stalling at random.
// Assumes the classifier's clock and reset; stall share set by the bench.
`timescale 1ns/1ns
module fbc_sink_model (
	input wire logic CLK,
	input wire logic RST,
	input wire logic [7:0] STALL_PCT,
	output logic READY = 1'h0
);
	// Ready is a level; a stalled cycle simply withholds it
	always @(posedge CLK or posedge RST) begin
		if (RST) READY <= 1'h0;
		else READY <= ($urandom % 100) >= STALL_PCT;
	end
endmodule : fbc_sink_model

// ### frame_basic_classifier_tb.sv
// Bench for the frame basic classifier: register access, corner and random frames.
// Assumes fbc_pkg, fbc_classifier and fbc_sink_model are compiled first.
`timescale 1ns/1ns
module frame_basic_classifier_tb;
	import fbc_pkg::*;
	logic clk = 0, rst = 1, ce = 1, rd = 0, wr = 0, fv = 0, frdy, rv, ordy, wq, ce_rand = 0;
	logic [9:0] adr = '0;
	logic [31:0] wd = '0, rdata;
	logic [31:0] sh [256];
	fbc_frame_s fin = '0;
	fbc_result_s res, e_m;
	fbc_result_s expq [$];
	int bad_count = 0, compares = 0, cyc = 0, sent = 0, drops = 0;
	always #10 clk = ~clk;
	always @(posedge clk) ce <= ce_rand ? (($urandom % 8) != 0) : 1'h1;
	fbc_classifier u_dut (.CLK(clk), .RST(rst), .CE(ce), .AVS_ADDRESS(adr), .AVS_READ(rd),
		.AVS_WRITE(wr), .AVS_WRITEDATA(wd), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wq),
		.FRM_IN(fin), .FRM_IN_VALID(fv), .FRM_IN_READY(frdy), .RES_OUT(res),
		.RES_OUT_VALID(rv), .RES_OUT_READY(ordy));
	fbc_sink_model u_sink (.CLK(clk), .RST(rst), .STALL_PCT(8'h28), .READY(ordy));
	task automatic chk_res(input fbc_result_s g, input fbc_result_s e);
		compares++;
		if (g !== e) begin
			bad_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk_res
	task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			bad_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk_word
	task automatic close_out();
		$display("TB: compares=%0d mismatches=%0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : close_out
	task automatic bus(input logic w, input int ix, input logic [31:0] d, output logic [31:0] q);
		@(posedge clk);
		adr <= {ix[7:0], 2'h0};
		wd <= d;
		wr <= w;
		rd <= !w;
		do @(posedge clk); while (wq !== 1'h0);
		q = rdata;
		wr <= 1'h0;
		rd <= 1'h0;
		if (w) sh[ix] = d;
	endtask : bus
	function automatic fbc_result_s expect_of(input fbc_frame_s f);
		fbc_result_s r;
		int v, k;
		logic l2, ip;
		logic [15:0] t;
		logic [31:0] e;
		r = '0;
		v = 0;
		for (int i = 0; i < 3; i++) begin
			k = 5;
			for (int j = 4; j >= 0; j--)
				if (f.tpid[i] === (j == 0 ? FBC_TPID_C : j == 1 ? FBC_TPID_S : sh[j + 1][15:0]))
					k = j;
			if (v == i && i < f.tag_cnt && k < 5 && !sh[0][i * 5 + k]) v++;
		end
		ip = f.is_ip && !f.over3;
		r.routable = ip && v == f.tag_cnt && sh[0][16 + v];
		l2 = f.dmac[47:8] == 40'h0180C20000 && f.dmac[7:6] == 2'h0 && (f.dmac[5] || !f.dmac[4]);
		for (int i = 0; i < 3; i++)
			if (sh[1][2 + 2 * i +: 2] == 2'h1 && v <= i || sh[1][2 + 2 * i +: 2] == 2'h2 && v > i)
				r.vlan_reject = 1'h1;
		if (l2 && f.tag_cnt == 2'h0) r.vlan_reject = 1'h0;
		r.discard = r.vlan_reject || sh[1][0] && f.smac[40] || sh[1][1] && (f.smac == 0 || f.dmac == 0);
		r.learn_disable = r.discard;
		r.pipeline_point = r.discard ? FBC_PP_CLASSIFIER : f.pipeline_point;
		e = sh[2];
		{r.classified_drop_level, r.classified_priority_class} = {e[8:7], e[6:4]};
		t = (e[0] && v >= 2) ? f.tci[1] : f.tci[0];
		if (e[1] && v > 0) {r.classified_drop_level, r.classified_priority_class} = sh[16 + {t[12], t[15:13]}][4:0];
		if (e[2] && ip && sh[64 + f.dscp][13]) {r.classified_priority_class, r.classified_drop_level} = sh[64 + f.dscp][12:8];
		if (f.cpu_redir && l2) r.classified_priority_class = sh[192 + {f.dmac[5], f.dmac[3:0]}][2:0];
		r.dscp = ip ? (sh[64 + f.dscp][7] ? sh[64 + f.dscp][6:1] : f.dscp) : 6'h0;
		if (ip && sh[64 + f.dscp][0]) r.dscp = sh[128 + r.classified_priority_class][5:0];
		r.codepoint_transparent_flag = e[3];
		return r;
	endfunction : expect_of
	function automatic fbc_frame_s rnd_frame();
		fbc_frame_s f;
		int k;
		k = $urandom % 4;
		f.dmac = {16'($urandom), $urandom};
		if (k == 0) f.dmac = {40'h0180C20000, 2'h0, 6'($urandom)};
		if (k == 1) f.dmac = '0;
		f.smac = ($urandom % 8 == 0) ? 48'h0 : {7'h0, 1'($urandom), 8'($urandom), $urandom};
		f.tag_cnt = 2'($urandom);
		f.over3 = f.tag_cnt == 2'h3 && $urandom % 3 == 0;
		for (int i = 0; i < 3; i++) begin
			k = $urandom % 6;
			f.tpid[i] = k == 0 ? FBC_TPID_C : k == 1 ? FBC_TPID_S : k == 5 ? 16'h1234 : sh[k + 1][15:0];
			f.tci[i] = 16'($urandom);
		end
		{f.is_ip, f.dscp, f.cpu_redir, f.pipeline_point} = 12'($urandom);
		return f;
	endfunction : rnd_frame
	task automatic send(input fbc_frame_s f);
		fv <= 1'h1;
		fin <= f;
		expq.push_back(expect_of(f));
		do @(posedge clk); while (!(ce === 1'h1 && frdy === 1'h1));
		sent++;
	endtask : send
	task automatic idle(input string name);
		fv <= 1'h0;
		ce_rand <= 1'h0;
		for (int i = 0; i < 400 && expq.size() > 0; i++) @(posedge clk);
		$display("TB: test %s done", name);
	endtask : idle
	always @(posedge clk) begin
		cyc++;
		if (!rst && ce === 1'h1 && rv === 1'h1 && ordy === 1'h1) begin
			e_m = (expq.size() > 0) ? expq.pop_front() : '1;
			drops += e_m.discard;
			chk_res(res, e_m);
		end
		if (cyc == 30000) begin
			bad_count++;
			close_out();
		end
	end
	initial begin
		fbc_frame_s f;
		logic [31:0] q;
		logic [7:0] lows [7] = '{8'h00, 8'h0F, 8'h10, 8'h1F, 8'h20, 8'h3F, 8'h40};
		logic [7:0] offs [3] = '{8'h10, 8'h48, 8'h90};
		void'($urandom(32'h26E8));
		foreach (sh[i]) sh[i] = '0;
		repeat (20) @(posedge clk);
		rst <= 1'h0;
		for (int i = 0; i < 4; i++) begin
			bus(0, i, 0, q);
			chk_word(q, 32'h0);
		end
		bus(1, 8'h30, 32'hFFFFFFFF, q);
		bus(0, 8'h30, 0, q);
		chk_word(q, 32'h0);
		sh[8'h30] = '0;
		for (int j = 0; j < 3; j++) bus(1, 3 + j, 32'h9100 + j * 256, q);
		for (int i = 0; i < 16; i++) bus(1, 16 + i, $urandom & 32'h1F, q);
		for (int i = 0; i < 64; i++) bus(1, 64 + i, $urandom & 32'h3FFF, q);
		for (int i = 0; i < 8; i++) bus(1, 128 + i, $urandom & 32'h3F, q);
		for (int i = 0; i < 32; i++) bus(1, 192 + i, $urandom & 32'h7, q);
		foreach (lows[i]) foreach (offs[k]) begin
			bus(0, lows[i] + offs[k], 0, q);
			chk_word(q, sh[lows[i] + offs[k]]);
		end
		$display("TB: test registers done");
		bus(1, 0, 32'h00027FFE, q);
		bus(1, 1, 32'h0, q);
		bus(1, 2, 32'h0, q);
		f = '0;
		{f.is_ip, f.smac, f.dmac} = {1'h1, 48'h1, 48'h2};
		send(f);
		f.tag_cnt = 2'h1;
		f.tpid = {3{FBC_TPID_C}};
		send(f);
		f.tpid[0] = FBC_TPID_S;
		send(f);
		f.tpid[0] = FBC_TPID_C;
		f.tag_cnt = 2'h2;
		send(f);
		idle("routing");
		bus(1, 1, 32'h4, q);
		f.tag_cnt = 2'h0;
		foreach (lows[i]) begin
			f.dmac = {40'h0180C20000, lows[i]};
			send(f);
		end
		idle("bypass");
		bus(1, 1, 32'h8, q);
		f.tag_cnt = 2'h1;
		f.dmac = 48'h0180C2000002;
		send(f);
		idle("tagged control");
		for (int p = 0; p < 4; p++) begin
			bus(1, 0, $urandom & 32'h000F7FFF, q);
			bus(0, 0, 0, q);
			chk_word(q & 32'h000F7FFF, sh[0]);
			bus(1, 1, {24'h0, 2'($urandom % 3), 2'($urandom % 3), 2'($urandom % 3), 2'($urandom)}, q);
			bus(1, 2, $urandom & 32'h1FF, q);
			ce_rand <= 1'h1;
			repeat (100) send(rnd_frame());
			idle("random");
		end
		bus(0, 6, 0, q);
		chk_word(q, {16'(drops), 16'(sent)});
		close_out();
	end
endmodule : frame_basic_classifier_tb
